// [src/rsfs_consts.svh]
// constants for the regulator startup and fault sequencer
// Contract
// R1 - shutdown: phase outputs high impedance
// R2 - shutdown until enable and biases valid
// R3 - no-load id codes force shutdown
// R4 - no-load: wait two cycles, then disable
// R5 - other code after no-load runs soft-start
// R6 - no-load code never clears overvoltage shutdown
// R7 - all conditions true: soft-start immediately
// R8 - 16-cycle delay, then step every 16
// R9 - drives off while feedback above reference
// R10 - precharged above target: drives at ramp end
// R11 - power ok low until soft-start completes
// R12 - power ok low on faults and disables
// R13 - undervoltage only drops power ok
// R14 - soft-start trip: max(target+150mV, fixed level); code trips on either comparator, i.e. at the lower level
// R15 - after soft-start trip is target+150mV only
// R16 - overvoltage release hysteresis 50mV or 100mV
// R17 - overvoltage: low gates high, power ok low
// R18 - open sense: shut down, restart soft-start
// R19 - overcurrent: switches off 4096 cycles
// R20 - retry soft-start indefinitely while enabled
// R21 - synchronise analog comparator inputs
`ifndef RSFS_CONSTS_SVH
`define RSFS_CONSTS_SVH
`define RSFS_SS_DELAY_CYC 16
`define RSFS_SS_STEP_CYC 16
`define RSFS_NOLOAD_DELAY_CYC 2
`define RSFS_OC_WAIT_CYC 4096
`define RSFS_DAC_W 8
`define RSFS_MODE_SIX 2'h0
`define RSFS_MODE_FIVE_A 2'h1
`define RSFS_MODE_FIVE_B 2'h2
`define RSFS_NOLOAD_SIX_A 6'h3f
`define RSFS_NOLOAD_SIX_B 6'h3e
`define RSFS_NOLOAD_FIVE 5'h1f
// reference is in 12.5mV steps; 150mV is 12 steps
`define RSFS_OV_REL_STEPS 8'h0c
`endif

// [src/rsfs_pkg.sv]
// types for the regulator startup and fault sequencer
package rsfs_pkg;
    typedef enum logic [2:0] {
        RSFS_SHUTDOWN = 3'b000,
        RSFS_NOLOAD_WAIT = 3'b001,
        RSFS_SS_DELAY = 3'b010,
        RSFS_SS_RAMP = 3'b011,
        RSFS_RUN = 3'b100,
        RSFS_OC_WAIT = 3'b101
    } rsfs_state_t;
endpackage

// [src/rsfs_sync.sv]
// two-flop synchroniser bank for analog comparator levels
`timescale 1ns/100ps
module rsfs_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) $error("rsfs_sync width must be positive");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in; // R21
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// [src/rsfs_sequencer.sv]
// sequencing and fault protection for a two-phase buck controller
`timescale 1ns/100ps
`include "rsfs_consts.svh"
module rsfs_sequencer import rsfs_pkg::*; #(
    parameter int PHASES = 2,
    parameter int OC_WAIT_CYC = `RSFS_OC_WAIT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    // comparator levels from the analog section, asynchronous
    input wire logic enable_threshold_in,
    input wire logic core_bias_ok,
    input wire logic driver_bias_supply,
    input wire logic feedback_above_ref,
    input wire logic output_below_uv_trip,
    input wire logic output_above_uv_release,
    input wire logic output_above_ov_rel,
    input wire logic output_above_ov_rel_hi,
    input wire logic output_above_ov_fixed,
    input wire logic output_above_ov_fixed_rel,
    input wire logic local_output_sense_high,
    input wire logic droop_above_overcurrent_setpoint,
    // processor code and mode strap, same-domain logic
    input wire logic [5:0] voltage_id_code,
    input wire logic [1:0] id_mode,
    input wire logic [`RSFS_DAC_W-1:0] id_target,
    // outputs
    output logic [PHASES-1:0] pwm_out,
    output logic [PHASES-1:0] pwm_oe,
    output logic [PHASES-1:0] low_side_gate,
    output logic power_ok_out_o,
    output logic power_ok_out_oe,
    output logic [`RSFS_DAC_W-1:0] ramp_ref,
    output logic ov_trip_shutdown_level,
    output logic ov_fixed_trip_sel,
    output logic overvoltage_guard
);
    localparam int NSYNC = 12;
    localparam int OCW = $clog2(OC_WAIT_CYC + 1);

    initial begin
        if (PHASES < 1 || PHASES > 2) $error("rsfs_sequencer supports one or two phases");
        if (OC_WAIT_CYC < 1) $error("rsfs_sequencer overcurrent wait must be positive");
    end

    // all analog levels enter through two flops
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    assign raw_in = {enable_threshold_in, core_bias_ok, driver_bias_supply, feedback_above_ref,
                     output_below_uv_trip, output_above_uv_release, output_above_ov_rel,
                     output_above_ov_rel_hi, output_above_ov_fixed, output_above_ov_fixed_rel,
                     local_output_sense_high, droop_above_overcurrent_setpoint};

    rsfs_sync #(.WIDTH(NSYNC)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(raw_in),
        .sync_out(syn)
    );

    logic en_s, vcc_s, driver_bias_supply_s, fb_hi_s, uv_trip_s, uv_rel_s;
    logic ov_rel_s, ov_rel_hi_s, ov_fix_s, ov_fix_rel_s, open_s, oc_s;
    assign {en_s, vcc_s, driver_bias_supply_s, fb_hi_s, uv_trip_s, uv_rel_s,
            ov_rel_s, ov_rel_hi_s, ov_fix_s, ov_fix_rel_s, open_s, oc_s} = syn;

    // no-load code decode per id mode
    logic noload;
    always_comb begin
        case (id_mode)
            `RSFS_MODE_SIX: noload = (voltage_id_code == `RSFS_NOLOAD_SIX_A) ||
                                     (voltage_id_code == `RSFS_NOLOAD_SIX_B); // R3
            `RSFS_MODE_FIVE_A,
            `RSFS_MODE_FIVE_B: noload = (voltage_id_code[4:0] == `RSFS_NOLOAD_FIVE); // R3
            default: noload = 1'b0;
        endcase
    end

    // bias and enable gate; enable hysteresis lives in the comparator
    logic powered;
    assign powered = en_s && vcc_s && driver_bias_supply_s; // R2

    // state registers
    rsfs_state_t state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [OCW-1:0] oc_cnt_r, oc_cnt_nxt;
    logic [`RSFS_DAC_W-1:0] ref_r, ref_nxt;
    logic drive_en_r, drive_en_nxt;
    logic ss_done_r, ss_done_nxt;
    logic ov_active_r, ov_active_nxt;
    logic ov_fixed_r, ov_fixed_nxt;
    logic uv_r, uv_nxt;
    logic ov_sd_lvl_r, ov_sd_lvl_nxt;

    // overvoltage trip selection: fixed level only counts before soft-start is done
    logic ov_fix_allowed;
    logic ov_trip_now;
    assign ov_fix_allowed = !ss_done_r; // R14 R15
    assign ov_trip_now = ov_rel_hi_s || (ov_fix_allowed && ov_fix_s); // R14

    // sequencing next-state logic
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        oc_cnt_nxt = oc_cnt_r;
        ref_nxt = ref_r;
        drive_en_nxt = drive_en_r;
        ss_done_nxt = ss_done_r;
        ov_sd_lvl_nxt = ov_sd_lvl_r;
        if (!powered) begin
            // loss of enable or bias overrides everything
            state_nxt = RSFS_SHUTDOWN; // R2
            ref_nxt = '0;
            drive_en_nxt = 1'b0;
            ss_done_nxt = 1'b0;
            ov_sd_lvl_nxt = 1'b1;
        end else if (open_s) begin
            // open sense line: shut down, resume from start of soft-start
            state_nxt = RSFS_SHUTDOWN; // R18
            ref_nxt = '0;
            drive_en_nxt = 1'b0;
            ss_done_nxt = 1'b0;
        end else if (oc_s && state_r != RSFS_OC_WAIT && state_r != RSFS_SHUTDOWN) begin
            state_nxt = RSFS_OC_WAIT; // R19
            oc_cnt_nxt = '0;
            drive_en_nxt = 1'b0;
            ss_done_nxt = 1'b0;
            ref_nxt = '0;
        end else begin
            case (state_r)
                RSFS_SHUTDOWN: begin
                    ov_sd_lvl_nxt = 1'b1;
                    if (!noload) begin
                        state_nxt = RSFS_SS_DELAY; // R7 R5
                        cnt_nxt = '0;
                        ref_nxt = '0;
                        ov_sd_lvl_nxt = 1'b0;
                    end
                end
                RSFS_NOLOAD_WAIT: begin
                    if (!noload) begin
                        state_nxt = RSFS_RUN;
                    end else if (cnt_r == 5'(`RSFS_NOLOAD_DELAY_CYC - 1)) begin
                        state_nxt = RSFS_SHUTDOWN; // R4
                        drive_en_nxt = 1'b0;
                        ss_done_nxt = 1'b0;
                        ref_nxt = '0;
                        ov_sd_lvl_nxt = 1'b1; // R4
                    end else begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                end
                RSFS_SS_DELAY: begin
                    if (noload) begin
                        state_nxt = RSFS_NOLOAD_WAIT;
                        cnt_nxt = '0;
                    end else if (cnt_r == 5'(`RSFS_SS_DELAY_CYC - 1)) begin
                        state_nxt = RSFS_SS_RAMP; // R8
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                end
                RSFS_SS_RAMP: begin
                    // drives come on once the reference passes the feedback node
                    if (!fb_hi_s) begin
                        drive_en_nxt = 1'b1; // R9
                    end
                    if (noload) begin
                        state_nxt = RSFS_NOLOAD_WAIT;
                        cnt_nxt = '0;
                    end else if (ref_r >= id_target) begin
                        state_nxt = RSFS_RUN;
                        drive_en_nxt = 1'b1; // R10
                        ss_done_nxt = 1'b1;
                    end else if (cnt_r == 5'(`RSFS_SS_STEP_CYC - 1)) begin
                        ref_nxt = ref_r + 8'h01; // R8
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                end
                RSFS_RUN: begin
                    // id changes in run track the target directly
                    ref_nxt = id_target;
                    if (noload) begin
                        state_nxt = RSFS_NOLOAD_WAIT; // R4
                        cnt_nxt = '0;
                    end
                end
                RSFS_OC_WAIT: begin
                    if (oc_cnt_r == OCW'(OC_WAIT_CYC - 1)) begin
                        state_nxt = RSFS_SS_DELAY; // R20
                        cnt_nxt = '0;
                    end else begin
                        oc_cnt_nxt = oc_cnt_r + 1'b1; // R19
                    end
                end
                default: begin
                    state_nxt = RSFS_SHUTDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= RSFS_SHUTDOWN;
            cnt_r <= '0;
            oc_cnt_r <= '0;
            ref_r <= '0;
            drive_en_r <= 1'b0;
            ss_done_r <= 1'b0;
            ov_sd_lvl_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            oc_cnt_r <= oc_cnt_nxt;
            ref_r <= ref_nxt;
            drive_en_r <= drive_en_nxt;
            ss_done_r <= ss_done_nxt;
            ov_sd_lvl_r <= ov_sd_lvl_nxt;
        end
    end

    // overvoltage and undervoltage monitors; the no-load path never touches ov state
    always_comb begin
        ov_active_nxt = ov_active_r; // R6
        ov_fixed_nxt = ov_fixed_r;
        uv_nxt = uv_r;
        if (!powered) begin
            ov_active_nxt = 1'b0;
            ov_fixed_nxt = 1'b0;
        end else if (!ov_active_r) begin
            if (ov_trip_now) begin
                ov_active_nxt = 1'b1; // R17
                ov_fixed_nxt = !ov_rel_hi_s; // R16
            end
        end else if (ov_fixed_r ? !ov_fix_rel_s : !ov_rel_s) begin
            // release 100mV below a fixed trip, 50mV below a relative one
            ov_active_nxt = 1'b0; // R16
            ov_fixed_nxt = 1'b0;
        end
        if (!powered || !ss_done_r) begin
            uv_nxt = 1'b0;
        end else if (uv_trip_s) begin
            uv_nxt = 1'b1; // R13
        end else if (uv_rel_s) begin
            uv_nxt = 1'b0; // R13
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ov_active_r <= 1'b0;
            ov_fixed_r <= 1'b0;
            uv_r <= 1'b0;
        end else begin
            ov_active_r <= ov_active_nxt;
            ov_fixed_r <= ov_fixed_nxt;
            uv_r <= uv_nxt;
        end
    end

    // output stage, registered except pwm_out and power_ok_out_o, which are tied low
    logic [PHASES-1:0] pwm_oe_nxt, lg_nxt;
    logic pok_nxt;
    logic driving;
    assign driving = drive_en_r && (state_r == RSFS_SS_RAMP || state_r == RSFS_RUN ||
                                    state_r == RSFS_NOLOAD_WAIT);

    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++) begin : g_phase
            // high impedance whenever not driving or in overvoltage; low side gates are on only during overvoltage
            assign pwm_oe_nxt[gi] = driving && !ov_active_r; // R1 R9
            assign lg_nxt[gi] = ov_active_r; // R17
        end
    endgenerate

    // power ok released only after soft-start and without faults; open drain low when enabled
    assign pok_nxt = ss_done_r && state_r == RSFS_RUN && !uv_r && !ov_active_r && !noload; // R11 R12

    logic [PHASES-1:0] pwm_oe_r, lg_r;
    logic pok_oe_r;
    logic [`RSFS_DAC_W-1:0] ramp_ref_r;
    logic ov_sd_out_r, ov_fix_sel_r, ovg_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_oe_r <= '0;
            lg_r <= '0;
            pok_oe_r <= 1'b1;
            ramp_ref_r <= '0;
            ov_sd_out_r <= 1'b1;
            ov_fix_sel_r <= 1'b0;
            ovg_r <= 1'b0;
        end else begin
            pwm_oe_r <= pwm_oe_nxt;
            lg_r <= lg_nxt;
            pok_oe_r <= !pok_nxt; // R12
            ramp_ref_r <= ref_r;
            ov_sd_out_r <= ov_sd_lvl_r;
            ov_fix_sel_r <= ov_fix_allowed;
            ovg_r <= ov_active_r;
        end
    end

    assign pwm_out = '0;
    assign pwm_oe = pwm_oe_r;
    assign low_side_gate = lg_r;
    assign power_ok_out_o = 1'b0;
    assign power_ok_out_oe = pok_oe_r;
    assign ramp_ref = ramp_ref_r;
    assign ov_trip_shutdown_level = ov_sd_out_r;
    assign ov_fixed_trip_sel = ov_fix_sel_r;
    assign overvoltage_guard = ovg_r;
endmodule

// [tb/rsfs_sequencer_properties.sv]
// concurrent checks on the sequencer top-level ports
`timescale 1ns/100ps
`include "rsfs_consts.svh"
module rsfs_sequencer_properties #(
    parameter int PHASES = 2,
    parameter int OC_WAIT_CYC = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable_threshold_in,
    input wire logic output_below_uv_trip,
    input wire logic output_above_ov_rel_hi,
    input wire logic droop_above_overcurrent_setpoint,
    input wire logic [5:0] voltage_id_code,
    input wire logic [1:0] id_mode,
    input wire logic [`RSFS_DAC_W-1:0] id_target,
    input wire logic [PHASES-1:0] pwm_oe,
    input wire logic [PHASES-1:0] low_side_gate,
    input wire logic power_ok_out_o,
    input wire logic power_ok_out_oe,
    input wire logic [`RSFS_DAC_W-1:0] ramp_ref,
    input wire logic ov_trip_shutdown_level,
    input wire logic overvoltage_guard
);
    logic [7:0] hold_r;
    logic [7:0] hold_nxt;
    logic [`RSFS_DAC_W-1:0] prev_r;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // cycles the reference has stood still; saturates so a long run never wraps
    always_comb begin
        hold_nxt = (ramp_ref != prev_r) ? 8'h00 : ((hold_r == 8'hff) ? hold_r : hold_r + 8'h01);
    end
    // registers for the step spacing counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_r <= 8'h00;
            prev_r <= '0;
        end else begin
            hold_r <= hold_nxt;
            prev_r <= ramp_ref;
        end
    end
    a_shutdown_hiz: assert property (!enable_threshold_in [*6] |-> pwm_oe == '0 && power_ok_out_oe)
        else $error("drives or power ok active while disabled");
    a_pok_open_drain: assert property (power_ok_out_o == 1'b0)
        else $error("power ok pin driven high");
    a_ov_clamp_gates: assert property (output_above_ov_rel_hi && !power_ok_out_oe |->
        ##[1:6] (overvoltage_guard && low_side_gate == '1 && power_ok_out_oe))
        else $error("overvoltage clamp missing");
    a_noload_two_wait: assert property ($changed(voltage_id_code) && voltage_id_code == 6'h3f && id_mode == 2'h0
        && !power_ok_out_oe |-> !ov_trip_shutdown_level ##1 !ov_trip_shutdown_level
        ##[1:5] (ov_trip_shutdown_level && pwm_oe == '0 && power_ok_out_oe))
        else $error("no-load shutdown timing wrong");
    a_ramp_step_space: assert property (ramp_ref == $past(ramp_ref) + 8'h01 && $past(ramp_ref) != '0
        |-> hold_r == 8'h0f)
        else $error("reference step spacing wrong");
    a_ramp_cap_target: assert property ($changed(ramp_ref) |-> ramp_ref <= id_target)
        else $error("reference passed target");
    a_oc_drives_off: assert property (droop_above_overcurrent_setpoint && !power_ok_out_oe |->
        ##[1:6] (pwm_oe == '0 && power_ok_out_oe))
        else $error("overcurrent did not stop drives");
    a_uv_pok_only: assert property (output_below_uv_trip && !power_ok_out_oe |->
        ##[1:6] (power_ok_out_oe && pwm_oe == '1))
        else $error("undervoltage action wrong");
    a_pok_after_ramp: assert property ($fell(power_ok_out_oe) |-> ramp_ref == id_target)
        else $error("power ok released before ramp end");
    c_ov_seen: cover property ($rose(overvoltage_guard));
    c_pok_released: cover property ($fell(power_ok_out_oe));
    c_ramp_step: cover property (ramp_ref == 8'h02 && $past(ramp_ref) == 8'h01);
endmodule

// [tb/rsfs_cpu_model.sv]
// processor side: presents the voltage id code just after clock edges
`timescale 1ns/100ps
module rsfs_cpu_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [5:0] code_req,
    output logic [5:0] voltage_id_code
);
    // a processor held in reset shows the no-load code, so the device must wait for a real one
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            voltage_id_code <= 6'h3f;
        end else begin
            voltage_id_code <= code_req;
        end
    end
endmodule

// [tb/rsfs_sequencer_bench.sv]
// self-checking bench for the regulator startup and fault sequencer
`timescale 1ns/100ps
module rsfs_sequencer_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic enable_threshold_in = 1'b0;
    logic core_bias_ok = 1'b1;
    logic driver_bias_supply = 1'b1;
    logic feedback_above_ref = 1'b1;
    logic output_below_uv_trip = 1'b0;
    logic output_above_uv_release = 1'b1;
    logic output_above_ov_rel = 1'b0;
    logic output_above_ov_rel_hi = 1'b0;
    logic output_above_ov_fixed = 1'b0;
    logic output_above_ov_fixed_rel = 1'b0;
    logic local_output_sense_high = 1'b0;
    logic droop_above_overcurrent_setpoint = 1'b0;
    logic [5:0] code_req = 6'h20;
    logic [5:0] voltage_id_code;
    logic [1:0] id_mode = 2'h0;
    logic [7:0] id_target = 8'h06;
    logic [1:0] pwm_out;
    logic [1:0] pwm_oe;
    logic [1:0] low_side_gate;
    logic power_ok_out_o;
    logic power_ok_out_oe;
    logic [7:0] ramp_ref;
    logic ov_trip_shutdown_level;
    logic ov_fixed_trip_sel;
    logic overvoltage_guard;
    logic [1:0] modes [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [5:0] codes [4] = '{6'h3f, 6'h3e, 6'h1f, 6'h1f};
    int err_count = 0;
    int n_tests = 0;
    int n;
    rsfs_sequencer #(.OC_WAIT_CYC(16)) DUT (.*);
    rsfs_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .code_req(code_req), .voltage_id_code(voltage_id_code));
    always #2 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // packs drives, clamp and power ok into one byte so a whole state is one compare
    task automatic look(input logic [7:0] exp);
        chk({2'h0, pwm_oe, low_side_gate, overvoltage_guard, power_ok_out_oe}, exp);
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic wait_pok(input logic want);
        for (int i = 0; i < 3000 && power_ok_out_oe !== want; i++) @(negedge clk);
        chk({7'h00, power_ok_out_oe}, {7'h00, want});
    endtask
    // counts cycles until the reference shows a value; bounded so a stuck ramp cannot hang
    task automatic wait_ref(input logic [7:0] v, output int c);
        c = 0;
        while (ramp_ref !== v && c < 3000) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        wait_cyc(30);
        look(8'h01);
        @(posedge clk);
        enable_threshold_in <= 1'b1;
        core_bias_ok <= 1'b0;
        wait_cyc(30);
        look(8'h01);
        @(posedge clk);
        core_bias_ok <= 1'b1;
        driver_bias_supply <= 1'b0;
        wait_cyc(30);
        look(8'h01);
        @(posedge clk);
        driver_bias_supply <= 1'b1;
        wait_ref(8'h01, n);
        chk(n[7:0], 8'd37);
        look(8'h01);
        chk({7'h00, ov_fixed_trip_sel}, 8'h01);
        wait_ref(8'h04, n);
        chk(n[7:0], 8'd48);
        @(posedge clk);
        feedback_above_ref <= 1'b0;
        wait_cyc(8);
        look(8'h31);
        wait_pok(1'b0);
        look(8'h30);
        chk({7'h00, ov_fixed_trip_sel}, 8'h00);
        @(posedge clk);
        output_below_uv_trip <= 1'b1;
        output_above_uv_release <= 1'b0;
        wait_cyc(8);
        look(8'h31);
        @(posedge clk);
        output_below_uv_trip <= 1'b0;
        output_above_uv_release <= 1'b1;
        wait_pok(1'b0);
        @(posedge clk);
        output_above_ov_rel_hi <= 1'b1;
        output_above_ov_rel <= 1'b1;
        wait_cyc(8);
        look(8'h0f);
        @(posedge clk);
        code_req <= 6'h3f;
        wait_cyc(10);
        chk({7'h00, overvoltage_guard}, 8'h01);
        @(posedge clk);
        code_req <= 6'h20;
        output_above_ov_rel_hi <= 1'b0;
        wait_cyc(8);
        chk({7'h00, overvoltage_guard}, 8'h01);
        @(posedge clk);
        output_above_ov_rel <= 1'b0;
        wait_pok(1'b0);
        look(8'h30);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            id_mode <= modes[i];
            code_req <= codes[i];
            wait_cyc(10);
            look(8'h01);
            chk({7'h00, ov_trip_shutdown_level}, 8'h01);
            @(posedge clk);
            code_req <= 6'h20;
            wait_pok(1'b0);
        end
        // output held above target: drives must wait out the whole ramp
        @(posedge clk);
        feedback_above_ref <= 1'b1;
        local_output_sense_high <= 1'b1;
        wait_cyc(8);
        look(8'h01);
        @(posedge clk);
        local_output_sense_high <= 1'b0;
        wait_ref(8'h05, n);
        look(8'h01);
        wait_pok(1'b0);
        look(8'h30);
        @(posedge clk);
        feedback_above_ref <= 1'b0;
        droop_above_overcurrent_setpoint <= 1'b1;
        wait_cyc(8);
        look(8'h01);
        wait_cyc(12);
        chk({6'h00, pwm_oe}, 8'h00);
        wait_cyc(300);
        chk({7'h00, power_ok_out_oe}, 8'h01);
        @(posedge clk);
        droop_above_overcurrent_setpoint <= 1'b0;
        wait_pok(1'b0);
        @(posedge clk);
        enable_threshold_in <= 1'b0;
        wait_cyc(8);
        look(8'h01);
        end_of_test();
    end
endmodule
bind rsfs_sequencer rsfs_sequencer_properties #(.PHASES(PHASES), .OC_WAIT_CYC(OC_WAIT_CYC)) u_props (.*);
